// ==== core/pief_pkg.sv ====
// constants for the peripheral interrupt enable and flag bank
package pief_pkg;
  // apb register byte addresses
  localparam logic [7:0] ADDR_ENABLE_C = 8'h00;
  localparam logic [7:0] ADDR_ENABLE_D = 8'h04;
  localparam logic [7:0] ADDR_REQUEST_A = 8'h08;
  localparam logic [7:0] ADDR_REQUEST_B = 8'h0c;
  localparam logic [7:0] ADDR_CORE_CTRL = 8'h10;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h14;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;
  // reset value of every register
  localparam logic [7:0] REG_RESET = 8'h00;
  // third enable register fields
  localparam int CAPCMP_SIX_IRQ_EN = 7;
  localparam int CAPCMP_FIVE_IRQ_EN = 6;
  localparam int CAPCMP_FOUR_IRQ_EN = 5;
  localparam int CAPCMP_THREE_IRQ_EN = 4;
  localparam int TIMER_SIX_MATCH_IRQ_EN = 3;
  localparam int TIMER_FIVE_OVF_IRQ_EN = 2;
  localparam int TIMER_FOUR_MATCH_IRQ_EN = 1;
  localparam int TIMER_THREE_OVF_IRQ_EN = 0;
  // fourth enable register fields
  localparam int CAPCMP_TEN_IRQ_EN = 7;
  localparam int CAPCMP_NINE_IRQ_EN = 6;
  localparam int UART_TWO_RX_IRQ_EN = 5;
  localparam int UART_TWO_TX_IRQ_EN = 4;
  localparam int CAPCMP_EIGHT_IRQ_EN = 3;
  localparam int CAPCMP_SEVEN_IRQ_EN = 2;
  localparam int SPORT_TWO_COLLISION_IRQ_EN = 1;
  localparam int SPORT_TWO_IRQ_EN = 0;
  // first request register fields
  localparam int TIMER_ONE_GATE_FLAG = 7;
  localparam int CONVERTER_DONE_FLAG = 6;
  localparam int UART_ONE_RX_FLAG = 5;
  localparam int UART_ONE_TX_FLAG = 4;
  localparam int SPORT_ONE_FLAG = 3;
  localparam int CAPCMP_ONE_FLAG = 2;
  localparam int TIMER_TWO_MATCH_FLAG = 1;
  localparam int TIMER_ONE_OVF_FLAG = 0;
  // second request register fields
  localparam int CONVERTER_TWO_FLAG = 6;
  localparam int SPORT_ONE_COLLISION_FLAG = 3;
  localparam int SPORT_TWO_COLLISION_FLAG = 2;
  localparam int TIMER_FOUR_MATCH_FLAG = 1;
  // access masks
  localparam logic [7:0] ENABLE_C_WR_MASK = 8'hff;
  localparam logic [7:0] ENABLE_D_WR_MASK = 8'hcf;
  localparam logic [7:0] REQ_A_IMPL_MASK = 8'hff;
  localparam logic [7:0] REQ_A_LEVEL_MASK = 8'h30;
  localparam logic [7:0] REQ_B_IMPL_MASK = 8'h4e;
  localparam logic [7:0] REQ_B_LEVEL_MASK = 8'h00;
  // core control register fields
  localparam int GLOBAL_IRQ_EN = 7;
  localparam int PERIPHERAL_IRQ_GATE_EN = 6;
  localparam logic [7:0] CORE_CTRL_WR_MASK = 8'hc0;
  // irq status and mask fields
  localparam int STS_REQ_RISE = 0;
  localparam int STS_REQ_FALL = 1;
  localparam int STS_STALE_EN = 2;
  localparam logic [2:0] STS_RESET = 3'h0;
endpackage

// ==== core/pief_flag_if.sv ====
// signals between the register front end and one request flag bank
`timescale 1ns/1ps
`default_nettype none
interface pief_flag_if;
  logic wr;
  logic [7:0] wdata;
  logic [7:0] evt;
  logic [7:0] flags;
  modport bank (input wr, input wdata, input evt, output flags);
  modport ctrl (output wr, output wdata, output evt, input flags);
endinterface
`default_nettype wire

// ==== core/pief_flag_bank.sv ====
// one eight-bit bank of peripheral interrupt request flags
`timescale 1ns/1ps
`default_nettype none
module pief_flag_bank
  import pief_pkg::*;
#(
  parameter logic [7:0] IMPL_MASK = 8'hff,
  parameter logic [7:0] LEVEL_MASK = 8'h00
) (
  input wire logic pclk,
  input wire logic presetn,
  pief_flag_if.bank fl
);

  logic [7:0] flags_q;
  logic [7:0] flags_d;

  // per bit: level bits follow the source, unimplemented bits stay zero, others are sticky
  for (genvar i = 0; i < 8; i++) begin : g_bit
    if (!IMPL_MASK[i]) begin : g_none
      assign flags_d[i] = 1'b0;
    end else if (LEVEL_MASK[i]) begin : g_level
      assign flags_d[i] = fl.evt[i];
    end else begin : g_sticky
      assign flags_d[i] = fl.evt[i] | (fl.wr ? fl.wdata[i] : flags_q[i]);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_q <= REG_RESET;
    end else begin
      flags_q <= flags_d;
    end
  end

  assign fl.flags = flags_q;
endmodule
`default_nettype wire

// ==== core/pief_top.sv ====
// peripheral interrupt enable and request register bank with apb access
//
// The APB interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - third enable register holds capcmp six..three, then four timer enables.
// - enable bit one lets its source interrupt, zero blocks it.
// - fourth enable register holds capcmp, uart two, sport two enables.
// - every implemented bit resets to zero on any reset.
// - uart one request bits and fourth enable bits 5:4 are read-only.
// - first request register holds eight timer, converter, uart, sport, capcmp flags.
// - request flag reads one while pending, zero otherwise.
// - flags set on their condition regardless of any enable.
// - second request register: converter two, two collisions, timer four.
// - second request bits 7, 5, 4, 0 read zero, writes ignored.
// - peripheral gate bit passes or blocks all pending sources at periph_irq_req; irq follows status and mask.
// - global enable bit zero blocks periph_irq_req; irq still follows the status and mask bits.
module pief_top
  import pief_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] req_a_evt,
  input wire logic [7:0] req_b_evt,
  input wire logic [7:0] ext_enable_a,
  input wire logic [7:0] ext_enable_b,
  input wire logic [7:0] ext_request_c,
  input wire logic [7:0] ext_request_d,
  output logic [7:0] enable_c,
  output logic [7:0] enable_d,
  output logic [7:0] request_a,
  output logic [7:0] request_b,
  output logic global_irq_en,
  output logic peripheral_irq_gate_en,
  output logic periph_irq_req,
  output logic irq
);

  // register state
  logic [7:0] enable_c_q;
  logic [7:0] enable_c_d;
  logic [7:0] enable_d_q;
  logic [7:0] enable_d_d;
  logic [7:0] core_ctrl_q;
  logic [7:0] core_ctrl_d;
  logic [2:0] sts_q;
  logic [2:0] sts_d;
  logic [2:0] mask_q;
  logic [2:0] mask_d;
  logic req_q;
  logic irq_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;

  // flag bank carriers
  pief_flag_if req_a_if ();
  pief_flag_if req_b_if ();

  // apb phase decode
  wire access_w = psel & penable;
  wire done_w = access_w & pready_q;
  wire wr_done_w = done_w & pwrite;
  wire lane0_w = pstrb[0];
  wire [7:0] wbyte_w = pwdata[7:0];

  // address decode
  wire hit_enc_w = (paddr == ADDR_ENABLE_C);
  wire hit_end_w = (paddr == ADDR_ENABLE_D);
  wire hit_rqa_w = (paddr == ADDR_REQUEST_A);
  wire hit_rqb_w = (paddr == ADDR_REQUEST_B);
  wire hit_ctl_w = (paddr == ADDR_CORE_CTRL);
  wire hit_sts_w = (paddr == ADDR_IRQ_STATUS);
  wire hit_msk_w = (paddr == ADDR_IRQ_MASK);
  wire hit_any_w = hit_enc_w | hit_end_w | hit_rqa_w | hit_rqb_w |
                   hit_ctl_w | hit_sts_w | hit_msk_w;

  // byte-lane write strobes, taken only on the completing edge
  wire wr_en_w = wr_done_w & lane0_w;
  wire wr_enc_w = wr_en_w & hit_enc_w;
  wire wr_end_w = wr_en_w & hit_end_w;
  wire wr_rqa_w = wr_en_w & hit_rqa_w;
  wire wr_rqb_w = wr_en_w & hit_rqb_w;
  wire wr_ctl_w = wr_en_w & hit_ctl_w;
  wire wr_sts_w = wr_en_w & hit_sts_w;
  wire wr_msk_w = wr_en_w & hit_msk_w;

  assign enable_c_d = wr_enc_w ?
    ((wbyte_w & ENABLE_C_WR_MASK) | (enable_c_q & ~ENABLE_C_WR_MASK)) :
    enable_c_q;

  assign enable_d_d = wr_end_w ?
    ((wbyte_w & ENABLE_D_WR_MASK) | (enable_d_q & ~ENABLE_D_WR_MASK)) :
    enable_d_q;

  // only the two gate bits of the core control byte are held here
  assign core_ctrl_d = wr_ctl_w ? (wbyte_w & CORE_CTRL_WR_MASK) : core_ctrl_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_c_q <= REG_RESET;
      enable_d_q <= REG_RESET;
      core_ctrl_q <= REG_RESET;
    end else begin
      enable_c_q <= enable_c_d;
      enable_d_q <= enable_d_d;
      core_ctrl_q <= core_ctrl_d;
    end
  end

  // first request register bank
  // first request layout
  assign req_a_if.wr = wr_rqa_w;
  assign req_a_if.wdata = wbyte_w;
  assign req_a_if.evt = req_a_evt;

  pief_flag_bank #(
    .IMPL_MASK(REQ_A_IMPL_MASK),
    .LEVEL_MASK(REQ_A_LEVEL_MASK)
  ) u_req_a (
    .pclk(pclk),
    .presetn(presetn),
    .fl(req_a_if.bank)
  );

  // second request register bank
  // second request layout
  assign req_b_if.wr = wr_rqb_w;
  assign req_b_if.wdata = wbyte_w;
  assign req_b_if.evt = req_b_evt;

  pief_flag_bank #(
    .IMPL_MASK(REQ_B_IMPL_MASK),
    .LEVEL_MASK(REQ_B_LEVEL_MASK)
  ) u_req_b (
    .pclk(pclk),
    .presetn(presetn),
    .fl(req_b_if.bank)
  );

  // gate bits taken from the core control byte
  wire gie_w = core_ctrl_q[GLOBAL_IRQ_EN];
  wire peripheral_irq_gate_en_w = core_ctrl_q[PERIPHERAL_IRQ_GATE_EN];

  wire [7:0] pend_a_w = req_a_if.flags & ext_enable_a;
  wire [7:0] pend_b_w = req_b_if.flags & ext_enable_b;
  wire [7:0] pend_c_w = ext_request_c & enable_c_q;
  wire [7:0] pend_d_w = ext_request_d & enable_d_q;
  wire any_pend_w = |{pend_a_w, pend_b_w, pend_c_w, pend_d_w};

  wire periph_pass_w = any_pend_w & peripheral_irq_gate_en_w;

  wire req_d_w = periph_pass_w & gie_w;

  // enabling a source whose flag is already up gives a stale interrupt
  // stale enable detected
  wire [7:0] new_c_w = enable_c_d & ~enable_c_q;
  wire [7:0] new_d_w = enable_d_d & ~enable_d_q;
  wire stale_w = |{new_c_w & ext_request_c, new_d_w & ext_request_d};

  // block events for the sticky status bits
  wire [2:0] evt_w = {stale_w, req_q & ~req_d_w, ~req_q & req_d_w};

  // status: set wins over write-one-to-clear
  assign sts_d = evt_w | (sts_q & ~(wr_sts_w ? wbyte_w[2:0] : 3'h0));
  assign mask_d = wr_msk_w ? wbyte_w[2:0] : mask_q;

  // core request, status, mask and interrupt line
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_q <= 1'b0;
      sts_q <= STS_RESET;
      mask_q <= STS_RESET;
      irq_q <= 1'b0;
    end else begin
      req_q <= req_d_w;
      sts_q <= sts_d;
      mask_q <= mask_d;
      irq_q <= |(sts_d & mask_d);
    end
  end

  // read data selection, unimplemented bits come back as zero
  // unimplemented read zero
  wire [7:0] rd_byte_w =
    hit_enc_w ? enable_c_q :
    hit_end_w ? enable_d_q :
    hit_rqa_w ? (req_a_if.flags & REQ_A_IMPL_MASK) :
    hit_rqb_w ? (req_b_if.flags & REQ_B_IMPL_MASK) :
    hit_ctl_w ? core_ctrl_q :
    hit_sts_w ? {5'h00, sts_q} :
    hit_msk_w ? {5'h00, mask_q} :
    8'h00;

  // one wait state: ready is raised after the first access cycle
  wire go_ready_w = access_w & ~pready_q;

  // apb answer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= go_ready_w;
      pslverr_q <= go_ready_w & ~hit_any_w;
      if (go_ready_w) begin
        prdata_q <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte_w};
      end
    end
  end

  // outputs straight from flip-flops
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign enable_c = enable_c_q;
  assign enable_d = enable_d_q;
  assign request_a = req_a_if.flags;
  assign request_b = req_b_if.flags;
  assign global_irq_en = gie_w;
  assign peripheral_irq_gate_en = peripheral_irq_gate_en_w;
  assign periph_irq_req = req_q;
  assign irq = irq_q;

endmodule
`default_nettype wire

// ==== test/pief_chk.sv ====
// port assertions for the interrupt enable and flag bank
`timescale 1ns/1ps
`default_nettype none
module pief_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] req_a_evt,
  input wire logic [7:0] req_b_evt,
  input wire logic [7:0] ext_enable_a,
  input wire logic [7:0] ext_enable_b,
  input wire logic [7:0] ext_request_c,
  input wire logic [7:0] ext_request_d,
  input wire logic [7:0] enable_c,
  input wire logic [7:0] enable_d,
  input wire logic [7:0] request_a,
  input wire logic [7:0] request_b,
  input wire logic global_irq_en,
  input wire logic peripheral_irq_gate_en,
  input wire logic periph_irq_req
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // any flag meeting its enable, before the core gates
  wire logic hit;
  wire logic open;
  assign hit = |{request_a & ext_enable_a, request_b & ext_enable_b,
    enable_c & ext_request_c, enable_d & ext_request_d};
  assign open = hit && global_irq_en && peripheral_irq_gate_en;
  property p_set_a; |(req_a_evt & 8'hcf) |=> (request_a & $past(req_a_evt)
    & 8'hcf) == ($past(req_a_evt) & 8'hcf); endproperty
  a_set_a: assert property (p_set_a)
    else $error("first flag not set");
  property p_set_b; |(req_b_evt & 8'h4e) |=> (request_b & $past(req_b_evt)
    & 8'h4e) == ($past(req_b_evt) & 8'h4e); endproperty
  a_set_b: assert property (p_set_b)
    else $error("second flag not set");
  property p_b_spare; (request_b & 8'hb1) == 8'h00; endproperty
  a_b_spare: assert property (p_b_spare)
    else $error("spare request bit set");
  property p_d_ro; (enable_d & 8'h30) == 8'h00; endproperty
  a_d_ro: assert property (p_d_ro)
    else $error("read-only enable bit set");
  property p_level; $past(presetn) |->
    request_a[5:4] == $past(req_a_evt[5:4]); endproperty
  a_level: assert property (p_level)
    else $error("uart flag not following source");
  property p_core; open ##1 open |-> periph_irq_req; endproperty
  a_core: assert property (p_core)
    else $error("core request missing");
  property p_blocked; !hit ##1 !hit |-> !periph_irq_req; endproperty
  a_blocked: assert property (p_blocked)
    else $error("request without enabled flag");
  property p_gate; !peripheral_irq_gate_en [*2] |-> !periph_irq_req;
  endproperty
  a_gate: assert property (p_gate)
    else $error("request with gate off");
  property p_global; !global_irq_en [*2] |-> !periph_irq_req; endproperty
  a_global: assert property (p_global)
    else $error("request with global off");
endmodule
bind pief_top pief_chk u_chk (.*);
`default_nettype wire

// ==== test/pief_far_model.sv ====
// peripheral sources and outer enable and request registers
`timescale 1ns/1ps
`default_nettype none
module pief_far_model (
  input wire logic pclk,
  output var logic [7:0] req_a_evt,
  output var logic [7:0] req_b_evt,
  output var logic [7:0] ext_enable_a,
  output var logic [7:0] ext_enable_b,
  output var logic [7:0] ext_request_c,
  output var logic [7:0] ext_request_d
);
  initial begin
    {req_a_evt, req_b_evt, ext_enable_a, ext_enable_b} = '0;
    {ext_request_c, ext_request_d} = '0;
  end
  // one-cycle pulses, uart one sources stay as levels
  task automatic fire(input logic [7:0] a, input logic [7:0] b);
    @(posedge pclk);
    req_a_evt <= a;
    req_b_evt <= b;
    @(posedge pclk);
    req_a_evt <= a & 8'h30;
    req_b_evt <= 8'h00;
  endtask
  // outer enables and flags that pair with the bank
  task automatic outer(input logic [7:0] ea, eb, rc, rd);
    @(posedge pclk);
    ext_enable_a <= ea;
    ext_enable_b <= eb;
    ext_request_c <= rc;
    ext_request_d <= rd;
  endtask
endmodule
`default_nettype wire

// ==== test/tb.sv ====
// self-checking bench for the interrupt enable and flag bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_errors++; \
  $display("ERROR %0t got %h want %h", $time, a, b); end end
module tb
  import pief_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
  logic global_irq_en, peripheral_irq_gate_en, periph_irq_req, irq;
  logic [7:0] paddr, req_a_evt, req_b_evt, ext_enable_a, ext_enable_b;
  logic [7:0] ext_request_c, ext_request_d, enable_c, enable_d;
  logic [7:0] request_a, request_b;
  logic [31:0] pwdata, prdata, rdat;
  logic [3:0] pstrb;
  int n_errors = 0;
  int n_compared = 0;
  pief_top u_dut (.*);
  pief_far_model u_far (.*);
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  // one apb transfer, held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= 4'h1;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    `CHK(pready, 1'b1)
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // let a write reach the registered outputs
  task automatic wait2();
    repeat (2) @(posedge pclk);
  endtask
  task automatic t_reset();
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, 8'(i * 4), '0);
      `CHK(rdat, 32'h0)
      `CHK(rerr, i == 7)
    end
  endtask
  task automatic t_enables();
    apb(1'b1, ADDR_ENABLE_C, 32'hff);
    apb(1'b1, ADDR_ENABLE_D, 32'hff);
    apb(1'b0, ADDR_ENABLE_C, '0);
    `CHK(rdat, 32'hff)
    apb(1'b0, ADDR_ENABLE_D, '0);
    `CHK(rdat, 32'hcf)
    `CHK(enable_d[UART_TWO_TX_IRQ_EN], 1'b0)
    apb(1'b1, ADDR_ENABLE_C, 32'h0);
    apb(1'b1, ADDR_ENABLE_D, 32'h0);
  endtask
  task automatic t_flags();
    u_far.fire(8'hff, 8'hff);
    apb(1'b0, ADDR_REQUEST_A, '0);
    `CHK(rdat, 32'hff)
    apb(1'b0, ADDR_REQUEST_B, '0);
    `CHK(rdat, 32'h4e)
    apb(1'b1, ADDR_REQUEST_A, 32'h0);
    apb(1'b1, ADDR_REQUEST_B, 32'hb1);
    apb(1'b0, ADDR_REQUEST_B, '0);
    `CHK(rdat, 32'h0)
    apb(1'b0, ADDR_REQUEST_A, '0);
    `CHK(rdat, 32'h30)
    u_far.fire(8'h00, 8'h00);
    apb(1'b0, ADDR_REQUEST_A, '0);
    `CHK(rdat, 32'h0)
  endtask
  task automatic t_core();
    u_far.outer(8'h01, 8'h00, 8'h80, 8'h00);
    apb(1'b1, ADDR_CORE_CTRL, 32'hc0);
    u_far.fire(8'h01, 8'h00);
    wait2();
    `CHK(periph_irq_req, 1'b1)
    apb(1'b1, ADDR_CORE_CTRL, 32'h80);
    wait2();
    `CHK(periph_irq_req, 1'b0)
    apb(1'b1, ADDR_CORE_CTRL, 32'h40);
    wait2();
    `CHK(periph_irq_req, 1'b0)
    apb(1'b1, ADDR_REQUEST_A, 32'h0);
    apb(1'b1, ADDR_CORE_CTRL, 32'hc0);
    wait2();
    `CHK(periph_irq_req, 1'b0)
    apb(1'b1, ADDR_ENABLE_C, 32'h80);
    wait2();
    `CHK(periph_irq_req, 1'b1)
  endtask
  task automatic t_irq();
    apb(1'b0, ADDR_IRQ_STATUS, '0);
    `CHK(rdat[STS_REQ_RISE], 1'b1)
    `CHK(rdat[STS_REQ_FALL], 1'b1)
    `CHK(rdat[STS_STALE_EN], 1'b1)
    `CHK(irq, 1'b0)
    apb(1'b1, ADDR_IRQ_MASK, 32'h1);
    wait2();
    `CHK(irq, 1'b1)
    apb(1'b1, ADDR_IRQ_STATUS, 32'h7);
    wait2();
    `CHK(irq, 1'b0)
  endtask
  // reset again in mid-run, with registers and the core request set
  task automatic t_rereset();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    `CHK(periph_irq_req, 1'b0)
    `CHK(irq, 1'b0)
    presetn <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      apb(1'b0, 8'(i * 4), '0);
      `CHK(rdat, 32'h0)
    end
  endtask
  // second request bank and fourth enable reach the core request
  task automatic t_outer_bd();
    u_far.outer(8'h00, 8'h02, 8'h00, 8'h01);
    apb(1'b1, ADDR_CORE_CTRL, 32'hff);
    apb(1'b0, ADDR_CORE_CTRL, '0);
    `CHK(rdat, 32'hc0)
    `CHK(global_irq_en, 1'b1)
    `CHK(peripheral_irq_gate_en, 1'b1)
    apb(1'b1, ADDR_ENABLE_D, 32'h01);
    wait2();
    `CHK(periph_irq_req, 1'b1)
    apb(1'b1, ADDR_ENABLE_D, 32'h00);
    u_far.fire(8'h00, 8'h02);
    wait2();
    `CHK(periph_irq_req, 1'b1)
    `CHK(request_b, 8'h02)
  endtask
  task automatic give_verdict();
    $display("mismatches %0d of %0d compared", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_enables();
    t_flags();
    t_core();
    t_irq();
    t_rereset();
    t_outer_bd();
    give_verdict();
  end
  // cut a hang short
  initial begin
    #100000;
    n_errors++;
    give_verdict();
  end
endmodule
`default_nettype wire
